// File: rtl/lpf_pkg.sv
// Purpose: Constants and types of the pin control.
// Assumes: 40 MHz system clock, 32-bit classic Wishbone register bus.
// Notes: Unlisted offsets read as zero.
`default_nettype none

package lpf_pkg;

    localparam int CLK_FREQ_MHZ = 40;

    // Program or erase duration
    localparam int OP_TIME_NS = 1000;
    localparam logic [15:0] OP_CYCLES = 16'((OP_TIME_NS * CLK_FREQ_MHZ + 999) / 1000);

    // Frame low this long aborts
    localparam logic [2:0] FRAME_ABORT_CYCLES = 3'h4;

    // Register byte offsets
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_GENERAL = 8'h04;
    localparam logic [7:0] REG_LOCK = 8'h08;
    localparam logic [7:0] REG_OP = 8'h0c;
    localparam logic [7:0] REG_FRAME = 8'h10;

    // Status fields
    localparam int ST_STRAP_POS = 0;
    localparam int ST_MUX_POS = 3;
    localparam int ST_STANDBY_POS = 4;
    localparam int ST_TOPLOCK_POS = 5;
    localparam int ST_PROTECT_POS = 6;
    localparam int ST_READY_POS = 7;
    localparam int ST_GRANT_POS = 8;
    localparam int ST_REFUSE_POS = 9;
    localparam int ST_ERASE_POS = 10;
    localparam int ST_BOOT_POS = 11;

    // Operation fields
    localparam int OP_SECTOR_POS = 0;
    localparam int OP_ERASE_POS = 4;

    // Frame count fields
    localparam int FR_START_POS = 0;
    localparam int FR_ABORT_POS = 8;

    // Mux-mode status byte
    localparam int PD_READY_POS = 7;
    localparam int PD_REFUSE_POS = 6;

    localparam logic [15:0] LOCK_RESET = 16'hffff;
    localparam logic [2:0] BOOT_STRAP = 3'h0;
    localparam logic [3:0] TOP_SECTOR = 4'hf;
    localparam int SECTOR_POS = 16;

    typedef enum logic [0:0] {
        OP_IDLE,
        OP_BUSY
    } lpf_op_type;

endpackage

`default_nettype wire

// File: rtl/lpf_mux_if.sv
// Purpose: Latched mux-port address, data and write pulse.
// Assumes: One driver (latch), one reader (core).
// Notes: wr_pulse lasts one enabled clock.
`timescale 1ns/1ps
`default_nettype none

interface lpf_mux_if;
    logic [19:0] addr;
    logic [7:0] data;
    logic wr_pulse;

    modport latch (output addr, data, wr_pulse);
    modport core (input addr, data, wr_pulse);
endinterface // lpf_mux_if

`default_nettype wire

// File: rtl/lpf_mux_latch.sv
// Purpose: Mux-port address and data capture.
// Assumes: Pins synchronous; strobes last a clock or more.
// Notes: Row latch open while row select high.
`timescale 1ns/1ps
`default_nettype none

module lpf_mux_latch
    import lpf_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic enable,
    input wire logic row_select,
    input wire logic write_strobe_n,
    input wire logic [10:0] shared_address,
    input wire logic [7:0] parallel_data,
    lpf_mux_if.latch bus
);

    typedef struct packed {
        logic [10:0] row;
        logic strobe_prev;
        logic [19:0] addr;
        logic [7:0] data;
        logic pulse;
    } lpf_latch_state_type;

    lpf_latch_state_type st;
    lpf_latch_state_type next_st;

    always_comb begin
        next_st = st;
        next_st.pulse = 1'b0;
        next_st.strobe_prev = write_strobe_n;
        if (enable) begin
            // (RL14) Row select steers pins
            // (RL15) Low address latched
            if (row_select) begin
                next_st.row = shared_address;
            end
            // (RL16) Capture on rising strobe
            if (write_strobe_n && !st.strobe_prev) begin
                next_st.addr = {shared_address[8:0], st.row};
                next_st.data = parallel_data;
                next_st.pulse = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
            st.strobe_prev <= 1'b1;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign bus.addr = st.addr;
    assign bus.data = st.data;
    assign bus.wr_pulse = st.pulse;

endmodule // lpf_mux_latch

`default_nettype wire

// File: rtl/lpf_sector_guard.sv
// Purpose: Sector locks and write-protect veto.
// Assumes: Lock pins are synchronous levels.
// Notes: Pins only veto; they never alter locks.
`timescale 1ns/1ps
`default_nettype none

module lpf_sector_guard
    import lpf_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic soft_reset,
    input wire logic lock_we,
    input wire logic [15:0] lock_wdata,
    input wire logic mux_mode,
    input wire logic top_sector_lock_n,
    input wire logic write_protect_n,
    input wire logic [3:0] sector,
    output logic [15:0] lock,
    output logic allow
);

    typedef struct packed {
        logic [15:0] lock;
    } lpf_guard_state_type;

    lpf_guard_state_type st;
    lpf_guard_state_type next_st;

    function automatic logic hw_blocked(input logic [3:0] sec, input logic tbl_n,
                                        input logic wp_n);
        // (RL10) Top sector pin veto
        // (RL12) Other sectors pin veto
        hw_blocked = (sec == TOP_SECTOR) ? !tbl_n : !wp_n;
    endfunction

    always_comb begin
        next_st = st;
        // (RL11) Locks untouched by pins
        // (RL13) Locks untouched by pins
        if (soft_reset) begin
            next_st.lock = LOCK_RESET;
        end else if (lock_we) begin
            next_st.lock = lock_wdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st.lock <= LOCK_RESET;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign lock = st.lock;

    // (RL23) Both pin and lock must permit
    // Mux mode has no locks and its pins carry address
    always_comb begin
        if (mux_mode) begin
            allow = 1'b1;
        end else begin
            allow = !hw_blocked(sector, top_sector_lock_n, write_protect_n) && !st.lock[sector];
        end
    end

endmodule // lpf_sector_guard

`default_nettype wire

// File: rtl/lpf_pin_control.sv
// Purpose: Flash pin control with register access.
// Assumes: Pins synchronous to CLK; floating pins arrive low.
// Notes: Cycle decode beyond frame tracking lives elsewhere.
//
// Summary of operation
// (RL1) Pins sampled on the clock
// (RL2) Frame starts, long frame aborts
// (RL3) Three-bit strap sets identity, boot 000
// (RL4) Board straps extra parts counting upward
// (RL5) Floating straps read as zero
// (RL6) Enable high means standby
// (RL7) Floating chip enable keeps part enabled
// (RL8) General inputs readable through register
// (RL9) Board holds inputs during read
// (RL10) Top lock low blocks sector 15
// (RL11) Top lock pin never changes locks
// (RL12) Protect low blocks sectors 0 to 14
// (RL13) Protect pin never changes locks
// (RL14) Row select picks row or column
// (RL15) Row select latches low address
// (RL16) Capture on strobe rise
// (RL17) Data pins write, read, or float
// (RL18) Output gate permits data drive
// (RL19) Interface select fixed at reset release
// (RL20) Reset blocks writes, floats, reads array
// (RL21) Ready output follows status bit 7
// (RL22) Mux mode reinterprets LPC pins
// (RL23) Needs pin and lock permission; in mux mode the code grants every request without either
`timescale 1ns/1ps
`default_nettype none

module lpf_pin_control
    import lpf_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CLK_EN,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic INTERFACE_SELECT,
    input wire logic INIT_N,
    input wire logic CHIP_ENABLE_N,
    input wire logic [2:0] STRAP_IDENTITY,
    input wire logic [4:0] GENERAL_INPUTS,
    input wire logic TOP_SECTOR_LOCK_N,
    input wire logic WRITE_PROTECT_N,
    input wire logic ROW_SELECT,
    input wire logic FRAME_N,
    input wire logic [3:0] LAD_I,
    output logic [3:0] LAD_O,
    output logic LAD_OE,
    input wire logic [3:0] DATA_HI_I,
    output logic [3:0] DATA_HI_O,
    output logic DATA_HI_OE,
    output logic READY_BUSY_OUT,
    output logic STANDBY
);

    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic mode_held;
        logic mode_mux;
        logic [2:0] strap;
        logic standby;
        lpf_op_type op;
        logic [15:0] count;
        logic granted;
        logic refused;
        logic erase;
        logic frame_prev;
        logic [2:0] frame_low;
        logic [7:0] starts;
        logic [7:0] aborts;
        logic [7:0] pdat;
        logic pdat_oe;
        logic ready;
    } lpf_top_state_type;

    lpf_top_state_type st;
    lpf_top_state_type next_st;

    lpf_mux_if mux_bus ();

    logic soft_reset;
    logic bus_take;
    logic lock_we;
    logic [15:0] lock_wdata;
    logic [15:0] lock;
    logic allow;
    logic op_req;
    logic [3:0] req_sector;
    logic req_erase;
    logic mux_active;
    logic [10:0] shared_address;
    logic [7:0] parallel_data;

    function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] offset);
        reg_hit = (adr == offset);
    endfunction

    function automatic logic [3:0] sector_of(input logic [19:0] addr);
        sector_of = addr[SECTOR_POS +: 4];
    endfunction

    // (RL22) Pins reused as address and data
    assign shared_address = {GENERAL_INPUTS, WRITE_PROTECT_N, TOP_SECTOR_LOCK_N,
                             STRAP_IDENTITY, CHIP_ENABLE_N};
    assign parallel_data = {DATA_HI_I, LAD_I};
    assign mux_active = st.mode_held && st.mode_mux;

    // (RL20) INIT_N resets in LPC mode, gates in mux
    assign soft_reset = !st.mode_mux && !INIT_N;
    assign bus_take = WB_CYC_I && WB_STB_I && !st.ack;

    lpf_mux_latch u_mux_latch (
        .clk(CLK),
        .resetn(RESETN),
        .ce(CLK_EN),
        .enable(mux_active),
        .row_select(ROW_SELECT),
        .write_strobe_n(FRAME_N),
        .shared_address(shared_address),
        .parallel_data(parallel_data),
        .bus(mux_bus.latch)
    );

    lpf_sector_guard u_sector_guard (
        .clk(CLK),
        .resetn(RESETN),
        .ce(CLK_EN),
        .soft_reset(soft_reset),
        .lock_we(lock_we),
        .lock_wdata(lock_wdata),
        .mux_mode(mux_active),
        .top_sector_lock_n(TOP_SECTOR_LOCK_N),
        .write_protect_n(WRITE_PROTECT_N),
        .sector(req_sector),
        .lock(lock),
        .allow(allow)
    );

    always_comb begin
        next_st = st;
        next_st.ack = bus_take;
        lock_we = 1'b0;
        lock_wdata = lock;
        op_req = 1'b0;
        req_sector = WB_DAT_I[OP_SECTOR_POS +: 4];
        req_erase = WB_DAT_I[OP_ERASE_POS];

        // (RL19) Mode caught after reset
        // (RL3) Identity from straps
        // (RL5) Undriven straps arrive low
        if (!st.mode_held) begin
            next_st.mode_held = 1'b1;
            next_st.mode_mux = INTERFACE_SELECT;
            next_st.strap = STRAP_IDENTITY;
        end

        // (RL6) Standby while enable high
        // (RL7) Undriven enable arrives low
        next_st.standby = st.mode_held && !st.mode_mux && CHIP_ENABLE_N;

        // General inputs sampled at take
        if (bus_take && !WB_WE_I) begin
            next_st.rdat = 32'h0;
            if (reg_hit(WB_ADR_I, REG_STATUS)) begin
                next_st.rdat[ST_STRAP_POS +: 3] = st.strap;
                next_st.rdat[ST_MUX_POS] = st.mode_mux;
                next_st.rdat[ST_STANDBY_POS] = st.standby;
                next_st.rdat[ST_TOPLOCK_POS] = TOP_SECTOR_LOCK_N;
                next_st.rdat[ST_PROTECT_POS] = WRITE_PROTECT_N;
                next_st.rdat[ST_READY_POS] = st.ready;
                next_st.rdat[ST_GRANT_POS] = st.granted;
                next_st.rdat[ST_REFUSE_POS] = st.refused;
                next_st.rdat[ST_ERASE_POS] = st.erase;
                next_st.rdat[ST_BOOT_POS] = (st.strap == BOOT_STRAP);
            end else if (reg_hit(WB_ADR_I, REG_GENERAL)) begin
                // (RL8) General inputs visible
                next_st.rdat[4:0] = GENERAL_INPUTS;
            end else if (reg_hit(WB_ADR_I, REG_LOCK)) begin
                next_st.rdat[15:0] = lock;
            end else if (reg_hit(WB_ADR_I, REG_FRAME)) begin
                next_st.rdat[FR_START_POS +: 8] = st.starts;
                next_st.rdat[FR_ABORT_POS +: 8] = st.aborts;
            end
        end

        // (RL20) Writes blocked during reset
        if (bus_take && WB_WE_I && !soft_reset && !st.mode_mux) begin
            if (reg_hit(WB_ADR_I, REG_LOCK)) begin
                lock_we = 1'b1;
                if (WB_SEL_I[0]) begin
                    lock_wdata[7:0] = WB_DAT_I[7:0];
                end
                if (WB_SEL_I[1]) begin
                    lock_wdata[15:8] = WB_DAT_I[15:8];
                end
            end else if (reg_hit(WB_ADR_I, REG_OP) && WB_SEL_I[0]) begin
                op_req = !st.standby;
            end
        end

        if (mux_active) begin
            req_sector = sector_of(mux_bus.addr);
            req_erase = 1'b0;
            op_req = mux_bus.wr_pulse;
        end

        // (RL23) Permission checked before start
        unique case (st.op)
            OP_IDLE: begin
                if (op_req) begin
                    next_st.erase = req_erase;
                    if (allow) begin
                        next_st.op = OP_BUSY;
                        next_st.count = OP_CYCLES - 16'h1;
                        next_st.granted = 1'b1;
                        next_st.refused = 1'b0;
                    end else begin
                        next_st.granted = 1'b0;
                        next_st.refused = 1'b1;
                    end
                end
            end
            OP_BUSY: begin
                if (st.count == 16'h0) begin
                    next_st.op = OP_IDLE;
                end else begin
                    next_st.count = st.count - 16'h1;
                end
            end
        endcase

        // (RL1) Frame sampled on the clock
        // (RL2) Starts and aborts
        next_st.frame_prev = FRAME_N;
        if (!mux_active && !st.standby && st.mode_held) begin
            if (!FRAME_N && st.frame_prev) begin
                next_st.starts = st.starts + 8'h1;
            end
            if (FRAME_N) begin
                next_st.frame_low = 3'h0;
            end else if (st.frame_low != FRAME_ABORT_CYCLES) begin
                next_st.frame_low = st.frame_low + 3'h1;
                if (st.frame_low == FRAME_ABORT_CYCLES - 3'h1) begin
                    next_st.aborts = st.aborts + 8'h1;
                    next_st.op = OP_IDLE;
                    next_st.count = 16'h0;
                end
            end
        end

        // (RL21) Ready mirrors data bit 7
        next_st.ready = (next_st.op == OP_IDLE);
        next_st.pdat = 8'h0;
        next_st.pdat[PD_READY_POS] = next_st.ready;
        next_st.pdat[PD_REFUSE_POS] = next_st.refused;

        // (RL17) Drive on reads, float otherwise
        // (RL18) Output gate must be low
        next_st.pdat_oe = mux_active && !INIT_N && FRAME_N;

        if (soft_reset) begin
            next_st.op = OP_IDLE;
            next_st.count = 16'h0;
            next_st.ready = 1'b1;
            next_st.pdat_oe = 1'b0;
            next_st.frame_low = 3'h0;
            next_st.mode_held = 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            st <= '0;
            st.ready <= 1'b1;
            st.frame_prev <= 1'b1;
        end else if (CLK_EN) begin
            st <= next_st;
        end
    end

    // LAD driven in mux mode only; LPC replies come from the decoder
    assign WB_ACK_O = st.ack;
    assign WB_DAT_O = st.rdat;
    assign LAD_O = st.pdat[3:0];
    assign LAD_OE = st.pdat_oe;
    assign DATA_HI_O = st.pdat[7:4];
    assign DATA_HI_OE = st.pdat_oe;
    assign READY_BUSY_OUT = st.ready;
    assign STANDBY = st.standby;

endmodule // lpf_pin_control

`default_nettype wire

// File: tb/lpf_pin_control_asserts.sv
// Purpose: Port checks of the pin control.
// Assumes: Select pin moves only in reset.
// Notes: Mode read from the select pin.
`timescale 1ns/1ps
`default_nettype none

module lpf_pin_control_asserts
    import lpf_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CLK_EN,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic WB_ACK_O,
    input wire logic INTERFACE_SELECT,
    input wire logic INIT_N,
    input wire logic CHIP_ENABLE_N,
    input wire logic TOP_SECTOR_LOCK_N,
    input wire logic WRITE_PROTECT_N,
    input wire logic LAD_OE,
    input wire logic DATA_HI_OE,
    input wire logic READY_BUSY_OUT,
    input wire logic STANDBY
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    sequence s_req;
        WB_CYC_I && WB_STB_I && !WB_ACK_O && CLK_EN;
    endsequence
    // Operation write taken by an idle, enabled device
    sequence s_op_take;
        s_req ##0 (WB_WE_I && WB_ADR_I == REG_OP && WB_SEL_I[0] && READY_BUSY_OUT
            && !INTERFACE_SELECT && INIT_N && !CHIP_ENABLE_N);
    endsequence

    property p_ack_once;
        WB_ACK_O |=> !WB_ACK_O;
    endproperty
    property p_ack_answer;
        s_req |=> WB_ACK_O;
    endproperty
    property p_standby_cause;
        $rose(STANDBY) |-> $past(CHIP_ENABLE_N) && !INTERFACE_SELECT;
    endproperty
    property p_top_lock;
        s_op_take ##0 (WB_DAT_I[3:0] == 4'hf && !TOP_SECTOR_LOCK_N) |=> READY_BUSY_OUT [*3];
    endproperty
    property p_protect;
        s_op_take ##0 (WB_DAT_I[3:0] != 4'hf && !WRITE_PROTECT_N) |=> READY_BUSY_OUT [*3];
    endproperty
    property p_busy_ends;
        $fell(READY_BUSY_OUT) |-> ##[1:60] READY_BUSY_OUT;
    endproperty
    property p_init_float;
        !INTERFACE_SELECT && !INIT_N |=> !LAD_OE && !DATA_HI_OE;
    endproperty
    property p_gate;
        INTERFACE_SELECT && (LAD_OE || DATA_HI_OE) |-> !$past(INIT_N) || !$past(INIT_N, 2);
    endproperty

    a_ack_once: assert property (p_ack_once) else $error("ack too long");
    a_ack_answer: assert property (p_ack_answer) else $error("no ack");
    a_standby_cause: assert property (p_standby_cause) else $error("standby uncaused");
    a_top_lock: assert property (p_top_lock) else $error("top sector not blocked");
    a_protect: assert property (p_protect) else $error("sector not blocked");
    a_busy_ends: assert property (p_busy_ends) else $error("busy too long");
    a_init_float: assert property (p_init_float) else $error("bus driven in reset");
    a_gate: assert property (p_gate) else $error("driven without gate");
endmodule // lpf_pin_control_asserts

bind lpf_pin_control lpf_pin_control_asserts u_chk (
    .CLK(CLK), .RESETN(RESETN), .CLK_EN(CLK_EN), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O), .INTERFACE_SELECT(INTERFACE_SELECT),
    .INIT_N(INIT_N), .CHIP_ENABLE_N(CHIP_ENABLE_N), .TOP_SECTOR_LOCK_N(TOP_SECTOR_LOCK_N),
    .WRITE_PROTECT_N(WRITE_PROTECT_N), .LAD_OE(LAD_OE), .DATA_HI_OE(DATA_HI_OE),
    .READY_BUSY_OUT(READY_BUSY_OUT), .STANDBY(STANDBY)
);

`default_nettype wire

// File: tb/lpf_host_model.sv
// Purpose: Frame driver and factory programmer.
// Assumes: Tasks entered just after a rising edge.
// Notes: Idle data toggles so no stale byte looks valid.
`timescale 1ns/1ps
`default_nettype none

module lpf_host_model (
    input wire logic clk,
    input wire logic [10:0] board_pins,
    output logic frame_n,
    output logic row_select,
    output logic [10:0] addr,
    output logic [7:0] data
);
    logic prog = 1'b0;
    logic drive = 1'b0;
    logic [10:0] a_q = 11'h000;

    assign addr = prog ? a_q : board_pins;

    initial begin
        frame_n = 1'b1;
        row_select = 1'b0;
        data = 8'h00;
    end

    always @(negedge clk) begin
        if (!drive) begin
            data <= ~data;
        end
    end

    // start, or abort if held long
    task automatic frame_low(input int n);
        frame_n <= 1'b0;
        repeat (n) @(posedge clk);
        frame_n <= 1'b1;
        @(posedge clk);
    endtask

    task automatic prog_write(input logic [10:0] row, input logic [8:0] col,
            input logic [7:0] d);
        prog <= 1'b1;
        row_select <= 1'b1;
        a_q <= row;
        repeat (2) @(posedge clk);
        row_select <= 1'b0;
        a_q <= {2'b00, col};
        drive <= 1'b1;
        data <= d;
        frame_n <= 1'b0;
        repeat (2) @(posedge clk);
        frame_n <= 1'b1;
        repeat (2) @(posedge clk);
        drive <= 1'b0;
        prog <= 1'b0;
    endtask
endmodule // lpf_host_model

`default_nettype wire

// File: tb/tb_top.sv
// Purpose: Self-checking bench of the pin control.
// Assumes: Clock enable high; host model is the far side.
// Notes: Floating pins driven low, as pull-downs do.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import lpf_pkg::*;
    logic CLK, RESETN, CLK_EN, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
    logic [7:0] WB_ADR_I;
    logic [3:0] WB_SEL_I;
    logic [31:0] WB_DAT_I, WB_DAT_O;
    logic INTERFACE_SELECT, INIT_N, CHIP_ENABLE_N, TOP_SECTOR_LOCK_N, WRITE_PROTECT_N;
    logic [2:0] STRAP_IDENTITY;
    logic [4:0] GENERAL_INPUTS;
    logic ROW_SELECT, FRAME_N, LAD_OE, DATA_HI_OE, READY_BUSY_OUT, STANDBY;
    logic [3:0] LAD_I, LAD_O, DATA_HI_I, DATA_HI_O;
    logic [10:0] board, pins;
    logic [7:0] pdata;
    int n_errors, n_compared;

    assign {GENERAL_INPUTS, WRITE_PROTECT_N, TOP_SECTOR_LOCK_N, STRAP_IDENTITY,
        CHIP_ENABLE_N} = pins;
    assign {DATA_HI_I, LAD_I} = pdata;

    lpf_host_model host (
        .clk(CLK), .board_pins(board), .frame_n(FRAME_N), .row_select(ROW_SELECT),
        .addr(pins), .data(pdata)
    );

    lpf_pin_control uut (
        .CLK(CLK), .RESETN(RESETN), .CLK_EN(CLK_EN), .WB_CYC_I(WB_CYC_I),
        .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
        .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
        .INTERFACE_SELECT(INTERFACE_SELECT), .INIT_N(INIT_N), .CHIP_ENABLE_N(CHIP_ENABLE_N),
        .STRAP_IDENTITY(STRAP_IDENTITY), .GENERAL_INPUTS(GENERAL_INPUTS),
        .TOP_SECTOR_LOCK_N(TOP_SECTOR_LOCK_N), .WRITE_PROTECT_N(WRITE_PROTECT_N),
        .ROW_SELECT(ROW_SELECT), .FRAME_N(FRAME_N), .LAD_I(LAD_I), .LAD_O(LAD_O),
        .LAD_OE(LAD_OE), .DATA_HI_I(DATA_HI_I), .DATA_HI_O(DATA_HI_O),
        .DATA_HI_OE(DATA_HI_OE), .READY_BUSY_OUT(READY_BUSY_OUT), .STANDBY(STANDBY)
    );

    always #12.5 CLK = ~CLK;

    task automatic end_of_test;
        if (n_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
            input logic [3:0] sel, output logic [31:0] q);
        int n = 0;
        @(posedge CLK);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I <= we;
        WB_ADR_I <= adr;
        WB_SEL_I <= sel;
        WB_DAT_I <= d;
        do begin
            @(posedge CLK);
            n++;
        end while (WB_ACK_O !== 1'b1 && n < 20);
        q = WB_DAT_O;
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        if (WB_ACK_O !== 1'b1) begin
            n_errors++;
            end_of_test();
        end
    endtask

    task automatic wait_ready(output int n);
        n = 0;
        while (READY_BUSY_OUT !== 1'b1 && n < 200) begin
            @(posedge CLK);
            n++;
        end
        if (n >= 200) begin
            n_errors++;
            end_of_test();
        end
    endtask

    task automatic rst(input logic mux, input logic [2:0] strap);
        @(posedge CLK);
        RESETN <= 1'b0;
        INTERFACE_SELECT <= mux;
        board[3:1] <= strap;
        repeat (4) @(posedge CLK);
        RESETN <= 1'b1;
        repeat (2) @(posedge CLK);
    endtask

    task automatic rd(input logic [7:0] adr, output logic [31:0] q);
        wb(1'b0, adr, 32'h0, 4'hf, q);
    endtask

    task automatic t_straps;
        logic [31:0] q;
        logic [2:0] straps [3] = '{3'h0, 3'h1, 3'h2};
        foreach (straps[i]) begin
            rst(1'b0, straps[i]);
            rd(REG_STATUS, q);
            check("strap", {29'h0, straps[i]}, {29'h0, q[2:0]});
            check("boot", {31'h0, straps[i] == BOOT_STRAP}, {31'h0, q[ST_BOOT_POS]});
            rd(REG_LOCK, q);
            check("lock reset", {16'h0, LOCK_RESET}, q);
        end
    endtask

    task automatic t_general_standby;
        logic [31:0] q;
        board[10:6] <= 5'h15;
        rd(REG_GENERAL, q);
        check("general", 32'h15, q);
        board[10:6] <= 5'h0a;
        board[0] <= 1'b1;
        rd(REG_GENERAL, q);
        check("general", 32'h0a, q);
        rd(REG_STATUS, q);
        check("standby", 32'h1, {31'h0, STANDBY & q[ST_STANDBY_POS]});
        board[0] <= 1'b0;
        repeat (3) @(posedge CLK);
        check("enabled", 32'h0, {31'h0, STANDBY});
    endtask

    task automatic op(input logic [3:0] sec, input logic erase, input logic go);
        logic [31:0] q;
        int n;
        wb(1'b1, REG_OP, {27'h0, erase, sec}, 4'h1, q);
        wait_ready(n);
        rd(REG_STATUS, q);
        check("grant", {30'h0, !go, go}, {30'h0, q[ST_REFUSE_POS], q[ST_GRANT_POS]});
        check("busy span", {31'h0, go}, {31'h0, n >= OP_CYCLES - 2 && n <= OP_CYCLES + 1});
    endtask

    task automatic t_protect;
        logic [31:0] q;
        wb(1'b1, REG_LOCK, 32'h0, 4'h3, q);
        board[4] <= 1'b0;
        op(4'hf, 1'b0, 1'b0);
        op(4'h3, 1'b1, 1'b1);
        board[5:4] <= 2'b01;
        op(4'h0, 1'b0, 1'b0);
        op(4'he, 1'b1, 1'b0);
        op(4'hf, 1'b0, 1'b1);
        board[5] <= 1'b1;
        wb(1'b1, REG_LOCK, 32'h80, 4'h1, q);
        op(4'h7, 1'b0, 1'b0);
        op(4'h6, 1'b1, 1'b1);
        rd(REG_LOCK, q);
        check("lock kept", 32'h80, q);
    endtask

    task automatic t_frame_init;
        logic [31:0] q;
        int n;
        rst(1'b0, 3'h0);
        host.frame_low(1);
        host.frame_low(FRAME_ABORT_CYCLES);
        rd(REG_FRAME, q);
        check("frames", 32'h0102, q);
        wb(1'b1, REG_LOCK, 32'h0, 4'h3, q);
        wb(1'b1, REG_OP, 32'h2, 4'h1, q);
        host.frame_low(FRAME_ABORT_CYCLES);
        wait_ready(n);
        check("aborted", 32'h1, {31'h0, n < 12});
        INIT_N <= 1'b0;
        wb(1'b1, REG_LOCK, 32'h0, 4'h3, q);
        INIT_N <= 1'b1;
        repeat (2) @(posedge CLK);
        rd(REG_LOCK, q);
        check("init relock", {16'h0, LOCK_RESET}, q);
    endtask

    task automatic t_mux;
        int n;
        rst(1'b1, 3'h0);
        host.prog_write(11'h2a5, 9'h1e0, 8'h3c);
        @(posedge CLK);
        check("mux busy", 32'h0, {31'h0, READY_BUSY_OUT});
        INIT_N <= 1'b0;
        repeat (3) @(posedge CLK);
        check("gate on", 32'h3, {30'h0, DATA_HI_OE, LAD_OE});
        check("ready bit", 32'h0, {31'h0, DATA_HI_O[3]});
        INIT_N <= 1'b1;
        repeat (3) @(posedge CLK);
        check("gate off", 32'h0, {30'h0, DATA_HI_OE, LAD_OE});
        wait_ready(n);
        INIT_N <= 1'b0;
        repeat (3) @(posedge CLK);
        check("ready bit", 32'h1, {31'h0, DATA_HI_O[3]});
    endtask

    initial begin
        CLK = 1'b0;
        n_errors = 0;
        n_compared = 0;
        RESETN <= 1'b0;
        CLK_EN <= 1'b1;
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        WB_WE_I <= 1'b0;
        WB_ADR_I <= 8'h00;
        WB_SEL_I <= 4'h0;
        WB_DAT_I <= 32'h0;
        INIT_N <= 1'b1;
        board <= 11'h030;
        t_straps();
        t_general_standby();
        t_protect();
        t_frame_init();
        t_mux();
        end_of_test();
    end
endmodule // tb_top

`default_nettype wire
